// [core/eic_defs.vh]
// Register map, field positions and reset values of the external
// interrupt edge controller. Definitions only; include by bare name.
`ifndef EIC_DEFS_VH
`define EIC_DEFS_VH

// Bus geometry
`define EIC_ADDR_W          6
`define EIC_DATA_W          32

// Register byte offsets, one aligned word each
`define EIC_OFF_EDGE_SEL    6'h00
`define EIC_OFF_WAKE_EDGE   6'h04
`define EIC_OFF_ENABLE      6'h08
`define EIC_OFF_REQ_FLAGS1  6'h0c
`define EIC_OFF_WAKE_FLAGS  6'h10
`define EIC_OFF_PIN_FUNC    6'h14
`define EIC_OFF_GLOBAL_MASK 6'h18
`define EIC_OFF_PRIO_LEVEL  6'h1c

// Edge select register: reserved bit 2 reads as one
`define EIC_EDGE_SEL_RST    8'h04
`define EIC_EDGE_SEL_WMASK  8'hfb
`define EIC_WAKE_EDGE_RST   8'h00

// Request flag register 1: bits 7..5 read as one
`define EIC_FLAGS1_RSVD     8'he0
`define EIC_FLAGS1_MASK     8'h1f

// Enable register fields
`define EIC_EN_WAKE_BIT     5
`define EIC_ENABLE_MASK     8'h3f
`define EIC_ENABLE_RST      8'h00

// Pin function register fields
`define EIC_PF_REQ_MASK     8'h1b
`define EIC_PF_SRC_BIT      16
`define EIC_PF_ECMODE_LO    17
`define EIC_PF_RST          19'h00000

// Event counter edge modes
`define EIC_EC_FALL         2'h0
`define EIC_EC_RISE         2'h1

// Priority fields: request pins, event counter, wakeup
`define EIC_PRIO_REQ_LO     0
`define EIC_PRIO_EC_LO      2
`define EIC_PRIO_WAKE_LO    4
`define EIC_PRIO_RST        6'h00
`define EIC_GMASK_RST       2'h0
`define EIC_GMASK_ALL_OFF   2'h3

// Number of sensed lines
`define EIC_LINES           16

`endif

// [core/eic_edge_det.v]
// Synchroniser, pin function gate and edge detector for all lines.
// Assumes pins are asynchronous; alternate sources are on ref_clk_i.
`timescale 1ns/10ps
`default_nettype none

module eic_edge_det #(
	parameter N = 16
) (
	input  wire         ref_clk_i,
	input  wire         sys_rst_i,
	input  wire [N-1:0] pin_i,
	input  wire [N-1:0] alt_i,
	input  wire [N-1:0] alt_sel_i,
	input  wire [N-1:0] func_i,
	input  wire [N-1:0] rise_i,
	input  wire [N-1:0] both_i,
	output wire [N-1:0] edge_o
);

	reg  [N-1:0] sync1_r;
	reg  [N-1:0] sync2_r;
	reg  [N-1:0] prev_r;
	wire [N-1:0] sample;
	wire [N-1:0] gated;

	// Two stages before any logic looks at a pin
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sync1_r <= {N{1'b1}};
			sync2_r <= {N{1'b1}};
		end else begin
			sync1_r <= pin_i;
			sync2_r <= sync1_r;
		end
	end

	// A line not in interrupt function idles high, so switching the
	// function over a low pin yields a real edge here
	assign sample = (alt_sel_i & alt_i) | (~alt_sel_i & sync2_r);
	assign gated  = (func_i & sample) | ~func_i;

	always @(posedge ref_clk_i) begin
		if (sys_rst_i)
			prev_r <= {N{1'b1}};
		else
			prev_r <= gated;
	end

	// Single-cycle set pulse per selected polarity
	assign edge_o = (both_i & (prev_r ^ gated)) |
	                (~both_i & rise_i & ~prev_r & gated) |
	                (~both_i & ~rise_i & prev_r & ~gated);

endmodule // eic_edge_det

`default_nettype wire

// [core/eic_ext_irq.v]
// External interrupt front end: edge sensing, request flags, masking,
// and an Avalon-MM register slave with one wait cycle per access.
// Assumes pins are asynchronous to ref_clk_i and the CPU sits on the bus.
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`include "eic_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module eic_ext_irq (
	input  wire                   ref_clk_i,
	input  wire                   sys_rst_i,
	// Avalon-MM slave
	input  wire [`EIC_ADDR_W-1:0] avs_address_i,
	input  wire                   avs_read_i,
	input  wire                   avs_write_i,
	input  wire [3:0]             avs_byteenable_i,
	input  wire [`EIC_DATA_W-1:0] avs_writedata_i,
	output reg  [`EIC_DATA_W-1:0] avs_readdata_o,
	output reg                    avs_waitrequest_o,
	// External pins
	input  wire                   nmi_pin_i,
	input  wire                   timer_event_pin_i,
	input  wire                   conv_trigger_pin_i,
	input  wire                   ext_request_pin_4_i,
	input  wire                   ext_request_pin_3_i,
	input  wire                   ext_request_pin_1_i,
	input  wire                   ext_request_pin_0_i,
	input  wire                   event_counter_request_pin_i,
	input  wire [7:0]             wakeup_pins_i,
	// Internal counter output, already on ref_clk_i
	input  wire                   event_counter_pwm_signal_i,
	// Requests toward the CPU core
	output reg                    nmi_req_o,
	output reg                    irq_req_o,
	output reg                    timer_edge_o,
	output reg                    conv_trigger_o
);

	// Access decode
	wire        req;
	wire        done;
	wire [3:0]  word;
	wire        wr_done;

	// Software visible state
	reg  [7:0]  edge_sel_r;
	reg  [7:0]  wake_edge_r;
	reg  [7:0]  enable_r;
	reg  [4:0]  flags1_r;
	reg  [7:0]  wake_flags_r;
	reg  [18:0] pin_func_r;
	reg  [1:0]  gmask_r;
	reg  [5:0]  prio_r;
	reg         last_func_r;

	// Next values
	reg  [7:0]  edge_sel_nxt;
	reg  [7:0]  wake_edge_nxt;
	reg  [7:0]  enable_nxt;
	reg  [4:0]  flags1_nxt;
	reg  [7:0]  wake_flags_nxt;
	reg  [18:0] pin_func_nxt;
	reg  [1:0]  gmask_nxt;
	reg  [5:0]  prio_nxt;
	reg  [4:0]  clr1;
	reg  [7:0]  clr_wake;
	reg  [31:0] rd_mux;
	reg         irq_nxt;
	reg  [31:0] wr_merge;

	// Edge detector hookup
	wire [15:0] pins;
	wire [15:0] alt;
	wire [15:0] alt_sel;
	wire [15:0] func;
	wire [15:0] rise;
	wire [15:0] both;
	wire [15:0] edges;
	wire [4:0]  set1;
	wire [1:0]  ec_mode;

	// Byte-lane merge of a write into a stored word
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] wdata;
		input [3:0]  be;
		integer      i;
		begin
			lane_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i])
					lane_merge[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
	endfunction

	// A level passes when it reaches the global mask level
	// Mask value 3 shuts every maskable level off, whatever its level
	function level_pass;
		input [1:0] level;
		input [1:0] gmask;
		begin
			if (gmask == `EIC_GMASK_ALL_OFF)
				level_pass = 1'b0;
			else
				level_pass = (level >= gmask);
		end
	endfunction

	// One wait cycle: request seen with waitrequest high, answered next
	// A registered stall costs a cycle but keeps the bus outputs clean
	assign req     = avs_read_i | avs_write_i;
	assign done    = req & ~avs_waitrequest_o;
	assign word    = avs_address_i[5:2];
	assign wr_done = done & avs_write_i;

	always @(posedge ref_clk_i) begin
		if (sys_rst_i)
			avs_waitrequest_o <= 1'b1;
		else
			avs_waitrequest_o <= ~(req & avs_waitrequest_o);
	end

	// Line order: req0, req1, counter, req3, req4, conv, timer, nmi, wake
	assign pins = {wakeup_pins_i, nmi_pin_i, timer_event_pin_i,
	               conv_trigger_pin_i, ext_request_pin_4_i,
	               ext_request_pin_3_i, event_counter_request_pin_i,
	               ext_request_pin_1_i, ext_request_pin_0_i};

	// Counter input may come from the internal pwm instead of the pin
	// Switching the source over differing levels gives a real edge
	assign alt     = {13'h0000, event_counter_pwm_signal_i, 2'h0};
	assign alt_sel = {13'h0000, pin_func_r[`EIC_PF_SRC_BIT], 2'h0};

	// Wakeup and request pins only sense when in interrupt function
	// Timer and trigger lines always sense; their pulses bypass flags
	assign func = {pin_func_r[15:8], 3'h7, pin_func_r[4:3], 1'b1,
	               pin_func_r[1:0]};

	// Polarity per line; counter may also take both edges
	assign ec_mode = pin_func_r[`EIC_PF_ECMODE_LO +: 2];
	assign rise = {wake_edge_r, edge_sel_r[7:3],
	               (ec_mode == `EIC_EC_RISE), edge_sel_r[1:0]};
	assign both = {13'h0000, ec_mode[1], 2'h0};

	// History resets high like an idle pin; an always-sensing line held low
	// through reset shows a falling edge a few cycles after release
	eic_edge_det #(
		.N         (`EIC_LINES)
	) u_edge (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.pin_i     (pins),
		.alt_i     (alt),
		.alt_sel_i (alt_sel),
		.func_i    (func),
		.rise_i    (rise),
		.both_i    (both),
		.edge_o    (edges)
	);

	assign set1 = edges[4:0];

	// Register writes; a write only touches enabled byte lanes.
	// Merging into the read view keeps one lane function for all words.
	always @* begin
		wr_merge      = lane_merge(rd_mux, avs_writedata_i,
		                           avs_byteenable_i);
		edge_sel_nxt  = edge_sel_r;
		wake_edge_nxt = wake_edge_r;
		enable_nxt    = enable_r;
		pin_func_nxt  = pin_func_r;
		gmask_nxt     = gmask_r;
		prio_nxt      = prio_r;
		if (wr_done) begin
			case (word)
			// Reserved bit 2 is forced back to one
			4'h0: begin
				edge_sel_nxt = (wr_merge[7:0] &
				               `EIC_EDGE_SEL_WMASK) |
				               `EIC_EDGE_SEL_RST;
			end
			// Every wakeup edge bit is plain read-write
			4'h1: begin
				wake_edge_nxt = wr_merge[7:0];
			end
			// Upper enable bits 7..6 are masked and stay zero
			4'h2: begin
				enable_nxt = wr_merge[7:0] & `EIC_ENABLE_MASK;
			end
			// Unused request positions stay zero
			4'h5: begin
				pin_func_nxt = wr_merge[18:0] & 19'h7ff1b;
			end
			// Global mask level
			4'h6: begin
				gmask_nxt = wr_merge[1:0];
			end
			// Priority fields of the three modules
			4'h7: begin
				prio_nxt = wr_merge[5:0];
			end
			// Flag words and holes change nothing here
			default: begin
				prio_nxt = prio_r;
			end
			endcase
		end
	end

	// Flag clears: a zero in an enabled lane clears, a one leaves it.
	// A clear that directly follows a function write is dropped.
	// Only lane 0 carries flag bits, so a clear needs it enabled.
	always @* begin
		clr1     = 5'h00;
		clr_wake = 8'h00;
		if (wr_done && !last_func_r && avs_byteenable_i[0]) begin
			if (word == 4'h3)
				clr1 = ~avs_writedata_i[4:0];
			if (word == 4'h4)
				clr_wake = ~avs_writedata_i[7:0];
		end
	end

	// Set beats clear in the same cycle, so the block itself never
	// drops an edge; a stale zero written by software still can
	always @* begin
		flags1_nxt     = (flags1_r & ~clr1) | set1;
		wake_flags_nxt = (wake_flags_r & ~clr_wake) |
		                 edges[15:8];
	end

	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			edge_sel_r   <= `EIC_EDGE_SEL_RST;
			wake_edge_r  <= `EIC_WAKE_EDGE_RST;
			enable_r     <= `EIC_ENABLE_RST;
			flags1_r     <= 5'h00;
			wake_flags_r <= 8'h00;
			pin_func_r   <= `EIC_PF_RST;
			gmask_r      <= `EIC_GMASK_RST;
			prio_r       <= `EIC_PRIO_RST;
		end else begin
			edge_sel_r   <= edge_sel_nxt;
			wake_edge_r  <= wake_edge_nxt;
			enable_r     <= enable_nxt;
			flags1_r     <= flags1_nxt;
			wake_flags_r <= wake_flags_nxt;
			pin_func_r   <= pin_func_nxt;
			gmask_r      <= gmask_nxt;
			prio_r       <= prio_nxt;
		end
	end

	// Remembers whether the last completed access switched a pin
	// function. Any completed access, read or write, counts as the
	// spacing instruction, so a clear placed right after the switch
	// is dropped and cannot wipe the flag the switch may have raised.
	always @(posedge ref_clk_i) begin
		if (sys_rst_i)
			last_func_r <= 1'b0;
		else if (done)
			last_func_r <= wr_done && (word == 4'h5);
	end

	// Read mux; reserved bits read back as fixed ones
	always @* begin
		case (word)
		4'h0: rd_mux = {24'h0, edge_sel_r | `EIC_EDGE_SEL_RST};
		4'h1: rd_mux = {24'h0, wake_edge_r};
		4'h2: rd_mux = {24'h0, enable_r};
		// Bits 7..5 have no flip-flops behind them
		4'h3: rd_mux = {24'h0, `EIC_FLAGS1_RSVD | {3'h0, flags1_r}};
		4'h4: rd_mux = {24'h0, wake_flags_r};
		4'h5: rd_mux = {13'h0, pin_func_r};
		4'h6: rd_mux = {30'h0, gmask_r};
		4'h7: rd_mux = {26'h0, prio_r};
		default: rd_mux = 32'h00000000;
		endcase
	end

	// Read data taken in the wait cycle, stands while waitrequest is low
	// Holding it between reads costs nothing and eases debugging
	always @(posedge ref_clk_i) begin
		if (sys_rst_i)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= rd_mux;
	end

	// Maskable request: enabled flag whose module level passes the mask
	// Flags are never gated by enable, so software can still poll a
	// masked line; only the request toward the core is gated
	always @* begin
		irq_nxt = 1'b0;
		if (level_pass(prio_r[`EIC_PRIO_REQ_LO +: 2], gmask_r) &&
		    |(flags1_r & enable_r[4:0] & 5'h1b))
			irq_nxt = 1'b1;
		if (level_pass(prio_r[`EIC_PRIO_EC_LO +: 2], gmask_r) &&
		    flags1_r[2] && enable_r[2])
			irq_nxt = 1'b1;
		if (level_pass(prio_r[`EIC_PRIO_WAKE_LO +: 2], gmask_r) &&
		    enable_r[`EIC_EN_WAKE_BIT] && |wake_flags_r)
			irq_nxt = 1'b1;
	end

	// Non-maskable and pass-through edges bypass every mask
	// Registered so every request output leaves from a flip-flop
	always @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			nmi_req_o      <= 1'b0;
			irq_req_o      <= 1'b0;
			timer_edge_o   <= 1'b0;
			conv_trigger_o <= 1'b0;
		end else begin
			nmi_req_o      <= edges[7];
			irq_req_o      <= irq_nxt;
			timer_edge_o   <= edges[6];
			conv_trigger_o <= edges[5];
		end
	end

endmodule // eic_ext_irq

`default_nettype wire

// [verif/eic_pin_src.sv]
// Model of the pin sources around the edge controller.
// Assumes the bench calls set_pin from its own clocked flow.
`timescale 1ns/10ps
`default_nettype none
module eic_pin_src (
	input  wire logic        ref_clk_i,
	output var  logic [16:0] pins_o
);
	// Pins 15..0 idle high so a function switch raises no flag
	initial pins_o = 17'h0ffff;
	// Moves one line just after an edge, as a real source would
	task automatic set_pin(input int n, input logic v);
		@(posedge ref_clk_i);
		pins_o[n] <= v;
	endtask
endmodule // eic_pin_src
`default_nettype wire

// [verif/eic_ext_irq_assertions.sv]
// Checker on the ports of the edge controller top.
// Assumes eic_defs.vh on the include path; bound below.
`include "eic_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module eic_chk (
	input wire logic                   ref_clk_i,
	input wire logic                   sys_rst_i,
	input wire logic [`EIC_ADDR_W-1:0] avs_address_i,
	input wire logic                   avs_read_i,
	input wire logic                   avs_write_i,
	input wire logic [3:0]             avs_byteenable_i,
	input wire logic [`EIC_DATA_W-1:0] avs_writedata_i,
	input wire logic [`EIC_DATA_W-1:0] avs_readdata_o,
	input wire logic                   avs_waitrequest_o,
	input wire logic                   nmi_pin_i,
	input wire logic                   timer_event_pin_i,
	input wire logic                   conv_trigger_pin_i,
	input wire logic                   nmi_req_o,
	input wire logic                   irq_req_o,
	input wire logic                   timer_edge_o,
	input wire logic                   conv_trigger_o
);
	logic [2:0] quiet_r;
	logic       gm_off_r;
	// Cycles since a pulsed pin moved; pulses need a recent cause
	always @(posedge ref_clk_i)
		if (sys_rst_i || $changed({nmi_pin_i, timer_event_pin_i,
			conv_trigger_pin_i}))
			quiet_r <= 3'h0;
		else if (quiet_r != 3'h7)
			quiet_r <= quiet_r + 3'h1;
	// Shadow of the all-off global mask setting
	always @(posedge ref_clk_i)
		if (sys_rst_i)
			gm_off_r <= 1'b0;
		else if (avs_write_i && !avs_waitrequest_o &&
			avs_address_i[5:2] == 4'h6 && avs_byteenable_i[0])
			gm_off_r <= (avs_writedata_i[1:0] == 2'h3);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence req_s; (avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence done_s; (avs_read_i || avs_write_i) && !avs_waitrequest_o;
	endsequence
	one_wait_a: assert property (req_s |=> done_s)
		else $error("access not answered in one wait");
	short_ack_a: assert property (done_s |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	rsvd_one_a: assert property (avs_read_i && !avs_waitrequest_o &&
		avs_address_i[5:2] == 4'h0 |-> avs_readdata_o[2])
		else $error("reserved edge bit read zero");
	nmi_short_a: assert property (nmi_req_o |=> !nmi_req_o)
		else $error("nmi pulse too long");
	tmr_short_a: assert property (timer_edge_o |=> !timer_edge_o)
		else $error("timer pulse too long");
	cnv_short_a: assert property (conv_trigger_o |=> !conv_trigger_o)
		else $error("trigger pulse too long");
	pulse_cause_a: assert property ((nmi_req_o || timer_edge_o ||
		conv_trigger_o) |-> quiet_r < 3'h7)
		else $error("pulse without pin change");
	mask_all_a: assert property (gm_off_r && $past(gm_off_r) |->
		!irq_req_o) else $error("request passed full mask");
	rst_quiet_a: assert property (disable iff (1'b0) sys_rst_i |=>
		avs_waitrequest_o && !irq_req_o && !nmi_req_o)
		else $error("outputs active after reset");
endmodule // eic_chk
bind eic_ext_irq eic_chk i_eic_chk (.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.nmi_pin_i(nmi_pin_i), .timer_event_pin_i(timer_event_pin_i),
	.conv_trigger_pin_i(conv_trigger_pin_i), .nmi_req_o(nmi_req_o),
	.irq_req_o(irq_req_o), .timer_edge_o(timer_edge_o),
	.conv_trigger_o(conv_trigger_o));
`default_nettype wire

// [verif/eic_ext_irq_bench.sv]
// Self-checking bench for the external interrupt edge controller.
// Assumes eic_defs.vh on the include path and the pin model beside it.
`include "eic_defs.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module eic_ext_irq_bench;
	logic        clk, rst, rd, wr, nmi, irq, tmr, cnv, wq;
	logic [5:0]  addr;
	logic [3:0]  be;
	logic [31:0] wd, rdata, q;
	logic [16:0] pins;
	logic [3:0]  pc [3], pb [3];
	int          errors = 0, n_tests = 0;
	eic_pin_src i_eic_pin_src (.ref_clk_i(clk), .pins_o(pins));
	eic_ext_irq i_eic_ext_irq (.ref_clk_i(clk), .sys_rst_i(rst),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_byteenable_i(be), .avs_writedata_i(wd),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wq),
		.nmi_pin_i(pins[0]), .timer_event_pin_i(pins[1]),
		.conv_trigger_pin_i(pins[2]), .ext_request_pin_0_i(pins[3]),
		.ext_request_pin_1_i(pins[4]), .ext_request_pin_3_i(pins[5]),
		.ext_request_pin_4_i(pins[6]),
		.event_counter_request_pin_i(pins[7]),
		.wakeup_pins_i(pins[15:8]), .event_counter_pwm_signal_i(pins[16]),
		.nmi_req_o(nmi), .irq_req_o(irq), .timer_edge_o(tmr),
		.conv_trigger_o(cnv));
	// Pulse counts of the three edge outputs
	always @(posedge clk) begin
		if (rst) begin
			pc <= '{4'h0, 4'h0, 4'h0};
		end else begin
			pc[0] <= pc[0] + {3'h0, nmi === 1'b1};
			pc[1] <= pc[1] + {3'h0, tmr === 1'b1};
			pc[2] <= pc[2] + {3'h0, cnv === 1'b1};
		end
	end
	// One bus access; held until waitrequest is sampled low
	task automatic acc(input logic w, input logic [5:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wd <= d;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (wq !== 1'b0 && i < 50);
		if (i >= 50) errors++;
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	// Pin move, then enough cycles for sync and flag update
	task automatic pin(input int n, input logic v);
		i_eic_pin_src.set_pin(n, v);
		repeat (8) @(posedge clk);
	endtask
	task automatic t_regs;
		rd_chk(6'h00, 32'h04);
		rd_chk(6'h04, 32'h00);
		rd_chk(6'h08, 32'h00);
		rd_chk(6'h0c, 32'he0);
		wr_reg(6'h00, 32'hff);
		rd_chk(6'h00, 32'hff);
		wr_reg(6'h00, 32'h00);
		rd_chk(6'h00, 32'h04);
		rd_chk(6'h20, 32'h00);
		wr_reg(6'h04, 32'h81);
		rd_chk(6'h04, 32'h81);
		$display("regs done");
	endtask
	task automatic t_req;
		wr_reg(6'h14, 32'h01);
		pin(3, 1'b0);
		`CHK(irq, 1'b0)
		wr_reg(6'h08, 32'h01);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		rd_chk(6'h0c, 32'he1);
		wr_reg(6'h18, 32'h01);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		wr_reg(6'h1c, 32'h01);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		wr_reg(6'h18, 32'h03);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		wr_reg(6'h00, 32'h01);
		wr_reg(6'h0c, 32'hfe);
		rd_chk(6'h0c, 32'he0);
		pin(3, 1'b1);
		rd_chk(6'h0c, 32'he1);
		wr_reg(6'h0c, 32'h00);
		rd_chk(6'h0c, 32'he0);
		$display("request done");
	endtask
	task automatic t_func;
		pin(4, 1'b0);
		wr_reg(6'h14, 32'h03);
		wr_reg(6'h0c, 32'hfd);
		repeat (8) @(posedge clk);
		rd_chk(6'h0c, 32'he2);
		wr_reg(6'h0c, 32'hfd);
		rd_chk(6'h0c, 32'he0);
		pin(4, 1'b1);
		$display("function switch done");
	endtask
	task automatic t_wake;
		wr_reg(6'h14, 32'h8103);
		pin(8, 1'b0);
		pin(8, 1'b1);
		pin(9, 1'b0);
		pin(15, 1'b0);
		pin(15, 1'b1);
		rd_chk(6'h10, 32'h81);
		pin(9, 1'b1);
		$display("wakeup done");
	endtask
	task automatic t_pulse;
		pb = pc;
		wr_reg(6'h00, 32'he1);
		for (int n = 0; n < 3; n++) begin
			pin(n, 1'b0);
			pin(n, 1'b1);
		end
		wr_reg(6'h00, 32'h01);
		for (int n = 0; n < 3; n++) pin(n, 1'b0);
		`CHK(pc[0] - pb[0], 4'h2)
		`CHK(pc[1] - pb[1], 4'h2)
		`CHK(pc[2] - pb[2], 4'h2)
		for (int n = 0; n < 3; n++) pin(n, 1'b1);
		$display("pulses done");
	endtask
	task automatic t_ec;
		wr_reg(6'h14, 32'h48103);
		pin(7, 1'b0);
		rd_chk(6'h0c, 32'he4);
		wr_reg(6'h0c, 32'hfb);
		pin(7, 1'b1);
		rd_chk(6'h0c, 32'he4);
		wr_reg(6'h0c, 32'hfb);
		wr_reg(6'h14, 32'h58103);
		wr_reg(6'h0c, 32'hfb);
		rd_chk(6'h0c, 32'he4);
		wr_reg(6'h0c, 32'hfb);
		rd_chk(6'h0c, 32'he0);
		wr_reg(6'h14, 32'h38103);
		pin(16, 1'b1);
		rd_chk(6'h0c, 32'he4);
		$display("counter done");
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Free-running clock at 125 MHz
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		tally_and_finish;
	end
	// Main sequence
	initial begin
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		addr = 6'h00;
		be = 4'hf;
		wd = 32'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_req;
		t_func;
		t_wake;
		t_pulse;
		t_ec;
		tally_and_finish;
	end
endmodule // eic_ext_irq_bench
`default_nettype wire
